// *** ubs_channel.v ***
`timescale 1ns/10ps
`include "ubs_defs.vh"
module ubs_channel (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  input  wire       ce,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata,
  // Serial link
  input  wire       crystal_clock_in,
  input  wire       rx_pin,
  output wire       tx_pin,
  input  wire       cts_n_pin,
  output wire       rts_n_pin,
  output wire       irq_n,
  output wire       sleep_active,
  // General purpose pins
  input  wire [7:0] io_pin_in,
  output wire [7:0] io_pin_out,
  output wire [7:0] io_pin_oe_n
);
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;
  localparam RX_STOP = 2'b11;

  wire [10:0] pin_s;
  reg         xtal_prev_q;
  reg         cts_prev_q;
  reg  [7:0]  lcr_q;
  reg  [7:0]  mcr_q;
  reg  [7:0]  ier_q;
  reg  [7:0]  fcr_q;
  reg  [7:0]  efr_q;
  reg  [7:0]  spr_q;
  reg  [7:0]  tcr_q;
  reg  [7:0]  tlr_q;
  reg  [15:0] div_q;
  reg  [7:0]  resume_char_first_q;
  reg  [7:0]  resume_char_second_q;
  reg  [7:0]  pause_char_first_q;
  reg  [7:0]  pause_char_second_q;
  reg  [7:0]  iodir_q;
  reg  [7:0]  ioout_q;
  reg  [7:0]  iointen_q;
  reg  [7:0]  ioctl_q;
  reg  [15:0] baud_cnt_q;
  reg  [1:0]  rx_st_q;
  reg  [3:0]  rx_os_q;
  reg  [2:0]  rx_bit_q;
  reg  [7:0]  rsh_q;
  reg         tx_run_q;
  reg  [3:0]  tx_os_q;
  reg  [3:0]  tx_bit_q;
  reg  [9:0]  tsh_q;
  reg         tx_empty_prev_q;
  reg         thr_flag_q;
  reg  [1:0]  lsr_err_q;
  reg         dcts_q;
  reg         xoff_flag_q;
  reg         cts_rise_q;
  reg         rts_rise_q;
  reg  [7:0]  rdata_q;
  reg  [7:0]  rd_d;
  reg         irq_n_q;
  reg         sleep_q;
  reg  [5:0]  iir_d;

  wire [10:0] pin_raw = {io_pin_in, cts_n_pin, rx_pin, crystal_clock_in};
  wire [7:0]  io_s = pin_s[10:3];
  wire        cts_s = pin_s[2];
  wire        rx_s = pin_s[1];
  wire        xtal_s = pin_s[0];
  wire        is_enh = (lcr_q == `UBS_LCR_ENH_KEY);
  wire        is_spec = lcr_q[`UBS_LCR_DLAB] & ~is_enh;
  wire        is_gen = ~lcr_q[`UBS_LCR_DLAB];
  wire        enh_on = efr_q[`UBS_EFR_ENH];
  wire        tcr_on = enh_on & mcr_q[`UBS_MCR_TCR];
  wire        one_entry = ~fcr_q[`UBS_FCR_EN];
  wire        wr_gen = reg_wr & is_gen;
  wire        rd_gen = reg_rd & is_gen;
  wire        thr_wr = wr_gen & (reg_addr == `UBS_OFS_HOLD);
  wire        rhr_rd = rd_gen & (reg_addr == `UBS_OFS_HOLD);
  wire        fcr_wr = wr_gen & (reg_addr == `UBS_OFS_FIFO);
  wire        iir_rd = rd_gen & (reg_addr == `UBS_OFS_FIFO);
  wire        lsr_rd = rd_gen & (reg_addr == `UBS_OFS_LSR);
  wire        msr_rd = rd_gen & (reg_addr == `UBS_OFS_MSR) & ~tcr_on;
  wire        rx_clr = fcr_wr & reg_wdata[`UBS_FCR_RXRST];
  wire        tx_clr = fcr_wr & reg_wdata[`UBS_FCR_TXRST];
  wire        xtal_edge = xtal_s & ~xtal_prev_q;
  wire [15:0] baud_next = baud_cnt_q + 16'h0001;
  wire        tick = xtal_edge & (div_q != 16'h0000) & (baud_next >= div_q);
  wire        rx_done = tick & (rx_st_q == RX_STOP) & (rx_os_q == `UBS_OS_LAST);
  wire        rx_push = rx_done & rx_s;
  wire [7:0]  rx_dout;
  wire [6:0]  rx_level;
  wire        rx_empty;
  wire        rx_full;
  wire [7:0]  tx_dout;
  wire [6:0]  tx_level;
  wire        tx_empty;
  wire        tx_full;
  wire        tx_pop = ~tx_run_q & ~tx_empty;
  wire        rts_fall = wr_gen & (reg_addr == `UBS_OFS_MCR) & mcr_q[`UBS_MCR_RTS]
                         & ~reg_wdata[`UBS_MCR_RTS];
  wire [7:0]  lsr_val = {1'b0, tx_empty & ~tx_run_q, tx_empty, 1'b0,
                         lsr_err_q[1], 1'b0, lsr_err_q[0], ~rx_empty};
  wire        int_rls = (|lsr_err_q) & ier_q[`UBS_IER_RLS];
  wire        int_rhr = ~rx_empty & ier_q[`UBS_IER_RHR];
  wire        int_thr = thr_flag_q & ier_q[`UBS_IER_THR];
  wire        int_ms = dcts_q & ier_q[`UBS_IER_MS];
  wire        int_xoff = xoff_flag_q & ier_q[`UBS_IER_XOFF];
  wire        int_hs = (cts_rise_q & ier_q[`UBS_IER_CTS]) | (rts_rise_q & ier_q[`UBS_IER_RTS]);
  wire        any_int = int_rls | int_rhr | int_thr | int_ms | int_xoff | int_hs;

  assign reg_rdata = rdata_q;
  assign tx_pin = tsh_q[0];
  assign rts_n_pin = ~mcr_q[`UBS_MCR_RTS];
  assign irq_n = irq_n_q;
  assign sleep_active = sleep_q;
  assign io_pin_out = ioout_q;
  assign io_pin_oe_n = ~iodir_q;

  ubs_fifo u_rx_fifo (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .clear     (rx_clr),
    .one_entry (one_entry),
    .push      (rx_push),
    .pop       (rhr_rd),
    .din       (rsh_q),
    .dout      (rx_dout),
    .level     (rx_level),
    .empty     (rx_empty),
    .full      (rx_full)
  );

  ubs_fifo u_tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .clear     (tx_clr),
    .one_entry (one_entry),
    .push      (thr_wr),
    .pop       (tx_pop),
    .din       (reg_wdata),
    .dout      (tx_dout),
    .level     (tx_level),
    .empty     (tx_empty),
    .full      (tx_full)
  );

  // Pins cross into the clock domain through two stages each.
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      assign pin_s[gi] = s2_q;
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
        end else if (ce) begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
    end
  endgenerate

  always @* begin
    if (int_rls) begin
      iir_d = `UBS_IIR_RLS;
    end else if (int_rhr) begin
      iir_d = `UBS_IIR_RHR;
    end else if (int_thr) begin
      iir_d = `UBS_IIR_THR;
    end else if (int_ms) begin
      iir_d = `UBS_IIR_MS;
    end else if (int_xoff) begin
      iir_d = `UBS_IIR_XOFF;
    end else if (int_hs) begin
      iir_d = `UBS_IIR_HS;
    end else begin
      iir_d = `UBS_IIR_NONE;
    end
  end

  always @* begin
    rd_d = 8'h00;
    if (reg_addr == `UBS_OFS_LCR) begin
      rd_d = lcr_q;
    end else if (reg_addr == `UBS_OFS_IODIR) begin
      rd_d = iodir_q;
    end else if (reg_addr == `UBS_OFS_IOSTATE) begin
      rd_d = io_s;
    end else if (reg_addr == `UBS_OFS_IOINTEN) begin
      rd_d = iointen_q;
    end else if (reg_addr == `UBS_OFS_IOCTL) begin
      rd_d = ioctl_q;
    end else if (is_spec) begin
      case (reg_addr)
        `UBS_OFS_DLL: rd_d = div_q[7:0];
        `UBS_OFS_DLH: rd_d = div_q[15:8];
        default: rd_d = 8'h00;
      endcase
    end else if (is_enh) begin
      case (reg_addr)
        `UBS_OFS_EFR: rd_d = efr_q;
        `UBS_OFS_RESUME_CHAR_FIRST: rd_d = resume_char_first_q;
        `UBS_OFS_RESUME_CHAR_SECOND: rd_d = resume_char_second_q;
        `UBS_OFS_PAUSE_CHAR_FIRST: rd_d = pause_char_first_q;
        `UBS_OFS_PAUSE_CHAR_SECOND: rd_d = pause_char_second_q;
        default: rd_d = 8'h00;
      endcase
    end else begin
      case (reg_addr)
        `UBS_OFS_HOLD: rd_d = rx_empty ? 8'h00 : rx_dout;
        `UBS_OFS_IER: rd_d = ier_q;
        `UBS_OFS_FIFO: rd_d = {fcr_q[`UBS_FCR_EN], fcr_q[`UBS_FCR_EN], iir_d};
        `UBS_OFS_MCR: rd_d = mcr_q;
        `UBS_OFS_LSR: rd_d = lsr_val;
        `UBS_OFS_MSR: rd_d = tcr_on ? tcr_q : {3'h0, ~cts_s, 3'h0, dcts_q};
        `UBS_OFS_SPR: rd_d = tcr_on ? tlr_q : spr_q;
        `UBS_OFS_TXLVL: rd_d = {1'b0, tx_level};
        `UBS_OFS_RXLVL: rd_d = {1'b0, rx_level};
        default: rd_d = 8'h00;
      endcase
    end
  end

  // Register writes and read data.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      lcr_q <= `UBS_RST_REG;
      mcr_q <= `UBS_RST_REG;
      ier_q <= `UBS_RST_REG;
      fcr_q <= `UBS_RST_REG;
      efr_q <= `UBS_RST_REG;
      spr_q <= `UBS_RST_REG;
      tcr_q <= `UBS_RST_REG;
      tlr_q <= `UBS_RST_REG;
      div_q <= `UBS_RST_DIV;
      resume_char_first_q <= `UBS_RST_REG;
      resume_char_second_q <= `UBS_RST_REG;
      pause_char_first_q <= `UBS_RST_REG;
      pause_char_second_q <= `UBS_RST_REG;
      iodir_q <= `UBS_RST_REG;
      ioout_q <= `UBS_RST_REG;
      iointen_q <= `UBS_RST_REG;
      ioctl_q <= `UBS_RST_REG;
      rdata_q <= 8'h00;
    end else if (ce) begin
      if (reg_rd) begin
        rdata_q <= rd_d;
      end
      if (reg_wr) begin
        case (reg_addr)
          `UBS_OFS_LCR: lcr_q <= reg_wdata;
          `UBS_OFS_IODIR: iodir_q <= reg_wdata;
          `UBS_OFS_IOSTATE: ioout_q <= reg_wdata;
          `UBS_OFS_IOINTEN: iointen_q <= reg_wdata;
          `UBS_OFS_IOCTL: ioctl_q <= reg_wdata & 8'h0F;
          default: ;
        endcase
        if (is_spec) begin
          case (reg_addr)
            `UBS_OFS_DLL: div_q[7:0] <= reg_wdata;
            `UBS_OFS_DLH: div_q[15:8] <= reg_wdata;
            default: ;
          endcase
        end else if (is_enh) begin
          case (reg_addr)
            `UBS_OFS_EFR: efr_q <= reg_wdata;
            `UBS_OFS_RESUME_CHAR_FIRST: resume_char_first_q <= reg_wdata;
            `UBS_OFS_RESUME_CHAR_SECOND: resume_char_second_q <= reg_wdata;
            `UBS_OFS_PAUSE_CHAR_FIRST: pause_char_first_q <= reg_wdata;
            `UBS_OFS_PAUSE_CHAR_SECOND: pause_char_second_q <= reg_wdata;
            default: ;
          endcase
        end else begin
          case (reg_addr)
            `UBS_OFS_IER: ier_q <= enh_on ? reg_wdata :
                                   ((ier_q & `UBS_ENH_MASK) | (reg_wdata & ~`UBS_ENH_MASK));
            `UBS_OFS_FIFO: fcr_q <= enh_on ? (reg_wdata & 8'hF1) :
                                    ((fcr_q & `UBS_FCR_ENH) | (reg_wdata & 8'hC1));
            `UBS_OFS_MCR: mcr_q <= enh_on ? reg_wdata :
                                   ((mcr_q & `UBS_MCR_ENH) | (reg_wdata & ~`UBS_MCR_ENH));
            `UBS_OFS_MSR: if (tcr_on) tcr_q <= reg_wdata;
            `UBS_OFS_SPR: if (tcr_on) tlr_q <= reg_wdata; else spr_q <= reg_wdata;
            default: ;
          endcase
        end
      end
    end
  end

  // Baud tick: sixteen ticks per bit, counted on crystal edges.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      xtal_prev_q <= 1'b1;
      baud_cnt_q <= 16'h0000;
    end else if (ce) begin
      xtal_prev_q <= xtal_s;
      if (xtal_edge) begin
        baud_cnt_q <= (baud_next >= div_q) ? 16'h0000 : baud_next;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st_q <= RX_IDLE;
      rx_os_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rsh_q <= 8'h00;
    end else if (ce && tick) begin
      rx_os_q <= rx_os_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_os_q <= 4'h0;
          if (!rx_s) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_os_q == `UBS_OS_MID) begin
            rx_os_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_st_q <= rx_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_os_q == `UBS_OS_LAST) begin
            rsh_q <= {rx_s, rsh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_os_q == `UBS_OS_LAST) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_run_q <= 1'b0;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tsh_q <= 10'h3FF;
    end else if (ce) begin
      if (tx_pop) begin
        tsh_q <= {1'b1, tx_dout, 1'b0};
        tx_run_q <= 1'b1;
        tx_os_q <= 4'h0;
        tx_bit_q <= 4'h0;
      end else if (tx_run_q && tick) begin
        tx_os_q <= tx_os_q + 4'h1;
        if (tx_os_q == `UBS_OS_LAST) begin
          tsh_q <= {1'b1, tsh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == 4'h9) begin
            tx_run_q <= 1'b0;
          end
        end
      end
    end
  end

  // Sticky sources; a new event wins over a clear in the same cycle.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_empty_prev_q <= 1'b1;
      cts_prev_q <= 1'b1;
      thr_flag_q <= 1'b0;
      lsr_err_q <= 2'b00;
      dcts_q <= 1'b0;
      xoff_flag_q <= 1'b0;
      cts_rise_q <= 1'b0;
      rts_rise_q <= 1'b0;
      irq_n_q <= 1'b1;
      sleep_q <= 1'b0;
    end else if (ce) begin
      tx_empty_prev_q <= tx_empty;
      cts_prev_q <= cts_s;
      if (tx_empty && !tx_empty_prev_q) begin
        thr_flag_q <= 1'b1;
      end else if (thr_wr || iir_rd) begin
        thr_flag_q <= 1'b0;
      end
      lsr_err_q[0] <= (rx_done & rx_s & rx_full) | (lsr_err_q[0] & ~lsr_rd);
      lsr_err_q[1] <= (rx_done & ~rx_s) | (lsr_err_q[1] & ~lsr_rd);
      dcts_q <= (cts_s ^ cts_prev_q) | (dcts_q & ~msr_rd);
      xoff_flag_q <= (rx_push & (rsh_q == pause_char_first_q)) | (xoff_flag_q & ~iir_rd);
      cts_rise_q <= (cts_s & ~cts_prev_q) | (cts_rise_q & ~iir_rd);
      rts_rise_q <= rts_fall | (rts_rise_q & ~iir_rd);
      irq_n_q <= ~any_int;
      sleep_q <= ier_q[`UBS_IER_SLEEP] & ~any_int & rx_empty & tx_empty & ~tx_run_q
                 & (rx_st_q == RX_IDLE);
    end
  end

endmodule

// *** ubs_defs.vh ***
// Summary of operation
// - Divisor bytes sit at 0x00/0x01 while format bit 7 set and format differs from 0xBF.
// - Enhanced set (feature, resume, pause chars) is visible only while format equals 0xBF.
// - General set, holding FIFOs and enables, decodes only while format bit 7 is zero.
// - Threshold and trigger registers reachable only with enhanced bit and modem bit 2 set.
// - Enable bits 7..4 and other enhanced bits ignore writes unless enhanced bit set.
// - Receive pin bits are shifted in and characters with a high stop bit enter a 64-byte FIFO.
// - With FIFOs disabled only entry zero of each FIFO holds the character.
// - A 64-byte transmit FIFO feeds the serialiser; writes while full are discarded.
// - Six enabled sources drive the active-low interrupt; handshake lines fire on rising change.
// - Enable bit 7 gates clear-to-send change, bit 6 request-to-send change; reset zero.
// - Enable bit 5 gates the pause character interrupt; reset zero.
// - Enable bit 4 permits sleep; reset zero.
// - Enable bit 3 gates the modem status interrupt; reset zero.
// - Enable bit 2 gates the line status error interrupt; reset zero.
// - Enable bit 1 gates the transmit holding interrupt; reset zero.
// - Enable bit 0 gates the receive data interrupt; reset zero.
// - Re-setting enable bit 1 alone never raises a fresh transmit interrupt.
// - Feature register: auto clear, auto request, special detect, enhanced, four flow bits.
// - The I/O direction, state, enable and control registers are one shared copy.
`ifndef UBS_DEFS_VH
`define UBS_DEFS_VH
`define UBS_OFS_HOLD    4'h0
`define UBS_OFS_IER     4'h1
`define UBS_OFS_FIFO    4'h2
`define UBS_OFS_LCR     4'h3
`define UBS_OFS_MCR     4'h4
`define UBS_OFS_LSR     4'h5
`define UBS_OFS_MSR     4'h6
`define UBS_OFS_SPR     4'h7
`define UBS_OFS_TXLVL   4'h8
`define UBS_OFS_RXLVL   4'h9
`define UBS_OFS_IODIR   4'hA
`define UBS_OFS_IOSTATE 4'hB
`define UBS_OFS_IOINTEN 4'hC
`define UBS_OFS_IOCTL   4'hE
`define UBS_OFS_DLL     4'h0
`define UBS_OFS_DLH     4'h1
`define UBS_OFS_EFR     4'h2
`define UBS_OFS_RESUME_CHAR_FIRST    4'h4
`define UBS_OFS_RESUME_CHAR_SECOND    4'h5
`define UBS_OFS_PAUSE_CHAR_FIRST   4'h6
`define UBS_OFS_PAUSE_CHAR_SECOND   4'h7
`define UBS_OFS_TCR     4'h6
`define UBS_OFS_TLR     4'h7
`define UBS_LCR_ENH_KEY 8'hBF
`define UBS_LCR_DLAB    7
`define UBS_EFR_ENH     4
`define UBS_MCR_RTS     1
`define UBS_MCR_TCR     2
`define UBS_FCR_EN      0
`define UBS_FCR_RXRST   1
`define UBS_FCR_TXRST   2
`define UBS_IER_RHR     0
`define UBS_IER_THR     1
`define UBS_IER_RLS     2
`define UBS_IER_MS      3
`define UBS_IER_SLEEP   4
`define UBS_IER_XOFF    5
`define UBS_IER_RTS     6
`define UBS_IER_CTS     7
`define UBS_ENH_MASK    8'hF0
`define UBS_MCR_ENH     8'hE4
`define UBS_FCR_ENH     8'h30
`define UBS_RST_REG     8'h00
`define UBS_RST_DIV     16'h0001
`define UBS_IIR_NONE    6'h01
`define UBS_IIR_RLS     6'h06
`define UBS_IIR_RHR     6'h04
`define UBS_IIR_THR     6'h02
`define UBS_IIR_MS      6'h00
`define UBS_IIR_XOFF    6'h10
`define UBS_IIR_HS      6'h20
`define UBS_FIFO_AW     6
`define UBS_OS_LAST     4'hF
`define UBS_OS_MID      4'h7
`endif

// *** ubs_fifo.v ***
`timescale 1ns/10ps
`include "ubs_defs.vh"
module ubs_fifo (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  input  wire       ce,
  // Control
  input  wire       clear,
  input  wire       one_entry,
  // Data
  input  wire       push,
  input  wire       pop,
  input  wire [7:0] din,
  output wire [7:0] dout,
  output wire [6:0] level,
  output wire       empty,
  output wire       full
);
  reg [7:0] mem [0:63];
  reg [5:0] wp_q;
  reg [5:0] rp_q;
  reg [6:0] cnt_q;
  wire [5:0] wa = one_entry ? 6'h00 : wp_q;
  wire [5:0] ra = one_entry ? 6'h00 : rp_q;
  wire       do_push = push & ~full;
  wire       do_pop = pop & ~empty;

  assign dout = mem[ra];
  assign level = cnt_q;
  assign empty = (cnt_q == 7'h00);
  assign full = one_entry ? ~empty : cnt_q[6];

  always @(posedge clk) begin
    if (ce && do_push) begin
      mem[wa] <= din;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_q <= 6'h00;
      rp_q <= 6'h00;
      cnt_q <= 7'h00;
    end else if (ce) begin
      if (clear) begin
        wp_q <= 6'h00;
        rp_q <= 6'h00;
        cnt_q <= 7'h00;
      end else begin
        if (do_push) begin
          wp_q <= wp_q + 6'h01;
        end
        if (do_pop) begin
          rp_q <= rp_q + 6'h01;
        end
        if (do_push && !do_pop) begin
          cnt_q <= cnt_q + 7'h01;
        end else if (do_pop && !do_push) begin
          cnt_q <= cnt_q - 7'h01;
        end
      end
    end
  end
endmodule

// *** ubs_channel_assertions.sv ***
`timescale 1ns/10ps
module ubs_channel_assertions (
  // Clock and reset
  input wire       clk,
  input wire       reset,
  input wire       ce,
  // Register port
  input wire [3:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Serial link
  input wire       crystal_clock_in,
  input wire       rx_pin,
  input wire       tx_pin,
  input wire       cts_n_pin,
  input wire       rts_n_pin,
  input wire       irq_n,
  input wire       sleep_active,
  // General purpose pins
  input wire [7:0] io_pin_in,
  input wire [7:0] io_pin_out,
  input wire [7:0] io_pin_oe_n
);
  reg  [7:0] fmt_q;
  reg  [7:0] en_q;
  reg  [7:0] feat_q;
  reg  [7:0] dir_q;
  wire       wr_g = reg_wr && ce;
  wire       rd_g = reg_rd && ce;
  // Shadow copies follow the bank decode so reads can be predicted.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fmt_q  <= 8'h00;
      en_q   <= 8'h00;
      feat_q <= 8'h00;
      dir_q  <= 8'h00;
    end else if (wr_g) begin
      if (reg_addr == 4'h3) fmt_q <= reg_wdata;
      if (reg_addr == 4'h1 && !fmt_q[7])
        en_q <= feat_q[4] ? reg_wdata : {en_q[7:4], reg_wdata[3:0]};
      if (reg_addr == 4'h2 && fmt_q == 8'hBF) feat_q <= reg_wdata;
      if (reg_addr == 4'hA) dir_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  reset_release_a: assert property ($fell(reset) |-> irq_n && tx_pin && rts_n_pin
    && !sleep_active) else $error("outputs not idle after reset");
  enables_quiet_a: assert property ((en_q == 8'h00 && $past(en_q) == 8'h00) |-> irq_n)
    else $error("interrupt with all sources disabled");
  start_bit_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
    else $error("start bit too short");
  sleep_gate_a: assert property (sleep_active |-> en_q[4] || $past(en_q[4]))
    else $error("sleep without permission");
  enables_read_a: assert property ((rd_g && reg_addr == 4'h1 && !fmt_q[7]) |=>
    reg_rdata == $past(en_q)) else $error("enable register readback wrong");
  feature_read_a: assert property ((rd_g && reg_addr == 4'h2 && fmt_q == 8'hBF) |=>
    reg_rdata == $past(feat_q)) else $error("feature register readback wrong");
  divisor_hidden_a: assert property ((rd_g && fmt_q == 8'hBF && reg_addr <= 4'h1) |=>
    reg_rdata == 8'h00) else $error("divisor visible in enhanced set");
  shared_dir_a: assert property (io_pin_oe_n == ~dir_q || io_pin_oe_n == ~$past(dir_q))
    else $error("pin enables differ from direction");
  cover property ($fell(irq_n));
  cover property ($fell(tx_pin));
  cover property (sleep_active);
endmodule
bind ubs_channel ubs_channel_assertions u_ubs_channel_assertions (
  .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .crystal_clock_in(crystal_clock_in), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin), .irq_n(irq_n),
  .sleep_active(sleep_active), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
  .io_pin_oe_n(io_pin_oe_n)
);

// *** ubs_link_peer.sv ***
`timescale 1ns/10ps
module ubs_link_peer (
  // Serial link
  input  wire   tx_pin,
  output reg    rx_pin,
  output reg    cts_n_pin,
  // Crystal
  output reg    crystal_clock_in
);
  reg     [7:0] got_byte;
  integer       got_count;
  integer       j;
  initial begin
    rx_pin = 1'b1;
    cts_n_pin = 1'b1;
    got_byte = 8'h00;
    got_count = 0;
    crystal_clock_in = 1'b0;
    forever #62.5 crystal_clock_in = ~crystal_clock_in;
  end
  // framed serial send
  // One bit lasts 16 crystal periods, which assumes a divisor of one.
  task send(input [7:0] b);
    integer n;
    begin
      rx_pin = 1'b0;
      #2000;
      for (n = 0; n < 8; n = n + 1) begin
        rx_pin = b[n];
        #2000;
      end
      rx_pin = 1'b1;
      #2000;
    end
  endtask
  task pulse_cts;
    begin
      cts_n_pin = 1'b0;
      #400;
      cts_n_pin = 1'b1;
    end
  endtask
  initial begin
    forever begin
      @(negedge tx_pin);
      #1000;
      for (j = 0; j < 8; j = j + 1) begin
        #2000;
        got_byte[j] = tx_pin;
      end
      got_count = got_count + 1;
      #2000;
    end
  end
endmodule

// *** ubs_channel_tb.sv ***
`timescale 1ns/10ps
module ubs_channel_tb;
  reg        clk;
  reg        reset;
  reg        ce;
  reg  [3:0] reg_addr;
  reg        reg_wr;
  reg        reg_rd;
  reg  [7:0] reg_wdata;
  reg  [7:0] io_pin_in;
  wire [7:0] reg_rdata;
  wire [7:0] io_pin_out;
  wire [7:0] io_pin_oe_n;
  wire       crystal_clock_in;
  wire       rx_pin;
  wire       tx_pin;
  wire       cts_n_pin;
  wire       rts_n_pin;
  wire       irq_n;
  wire       sleep_active;
  integer    num_errors;
  integer    samples_checked;
  integer    i;
  reg  [7:0] v;
  ubs_channel u_ubs_channel (
    .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .crystal_clock_in(crystal_clock_in), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin), .irq_n(irq_n),
    .sleep_active(sleep_active), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
    .io_pin_oe_n(io_pin_oe_n)
  );
  ubs_link_peer u_ubs_link_peer (
    .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin),
    .crystal_clock_in(crystal_clock_in)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input [63:0] what, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // reserved bits zero
  // Every caller passes zero in reserved positions.
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task rchk(input [3:0] a, input [7:0] exp);
    begin
      rd(a, v);
      check("register", v, exp);
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wait_irq;
    integer n;
    begin
      for (n = 0; n < 3000 && irq_n !== 1'b0; n = n + 1) @(posedge clk);
      #1 check("irq_n", irq_n, 1'b0);
    end
  endtask
  task wait_byte(input [7:0] exp);
    integer c;
    integer n;
    begin
      c = u_ubs_link_peer.got_count;
      for (n = 0; n < 4000 && u_ubs_link_peer.got_count == c; n = n + 1) @(posedge clk);
      check("tx byte", u_ubs_link_peer.got_byte, exp);
    end
  endtask
  task t_reset;
    begin
      check("idle", {tx_pin, irq_n, rts_n_pin, sleep_active}, 8'h0E);
      check("pins", io_pin_oe_n & ~io_pin_out, 8'hFF);
      rchk(4'h1, 8'h00);
      wr(4'h3, 8'h80);
      rchk(4'h0, 8'h01);
      rchk(4'h1, 8'h00);
    end
  endtask
  task t_banks;
    begin
      wr(4'h0, 8'h34);
      wr(4'h1, 8'h12);
      rchk(4'h0, 8'h34);
      rchk(4'h1, 8'h12);
      rchk(4'h2, 8'h00);
      wr(4'h3, 8'hBF);
      rchk(4'h0, 8'h00);
      for (i = 4; i < 8; i = i + 1) wr(i[3:0], 8'h11 * i[7:0]);
      for (i = 4; i < 8; i = i + 1) rchk(i[3:0], 8'h11 * i[7:0]);
      wr(4'h3, 8'h80);
      wr(4'h0, 8'h01);
      wr(4'h1, 8'h00);
      wr(4'h3, 8'h03);
      rchk(4'h7, 8'h00);
    end
  endtask
  task t_protect;
    begin
      wr(4'h1, 8'hFF);
      rchk(4'h1, 8'h0F);
      wr(4'h1, 8'h00);
      wr(4'h3, 8'hBF);
      wr(4'h2, 8'h10);
      rchk(4'h2, 8'h10);
      wr(4'h3, 8'h03);
      wr(4'h1, 8'h10);
      rchk(4'h1, 8'h10);
      cyc(100);
      check("sleep", sleep_active, 1'b1);
      wr(4'h1, 8'h00);
      cyc(3);
      check("sleep", sleep_active, 1'b0);
      wr(4'hA, 8'h0F);
      wr(4'hB, 8'hA5);
      cyc(3);
      check("pins", io_pin_oe_n, 8'hF0);
      check("pins", io_pin_out, 8'hA5);
      rchk(4'hB, 8'h3C);
    end
  endtask
  task t_thr;
    begin
      wr(4'h0, 8'h5A);
      cyc(4);
      wr(4'h0, 8'hA6);
      wr(4'h0, 8'h3C);
      wait_byte(8'h5A);
      wait_byte(8'hA6);
      cyc(2500);
      check("tx count", u_ubs_link_peer.got_count, 8'h02);
      check("irq_n", irq_n, 1'b1);
      wr(4'h1, 8'h02);
      cyc(3);
      check("irq_n", irq_n, 1'b0);
      rchk(4'h2, 8'h02);
      cyc(2);
      check("irq_n", irq_n, 1'b1);
      wr(4'h1, 8'h00);
      wr(4'h1, 8'h02);
      cyc(3);
      check("irq_n", irq_n, 1'b1);
      wr(4'h1, 8'h00);
    end
  endtask
  task t_modem;
    integer j;
    reg [7:0] en;
    begin
      for (j = 0; j < 3; j = j + 1) begin
        en = (j == 0) ? 8'h80 : (j == 1) ? 8'h08 : 8'h40;
        wr(4'h1, en);
        if (j < 2) begin
          u_ubs_link_peer.pulse_cts;
        end else begin
          wr(4'h4, 8'h02);
          wr(4'h4, 8'h00);
        end
        wait_irq;
        rchk(4'h2, (j == 1) ? 8'h00 : 8'h20);
        rd(4'h6, v);
        cyc(3);
        check("irq_n", irq_n, 1'b1);
        wr(4'h1, 8'h00);
      end
    end
  endtask
  task t_rx;
    begin
      wr(4'h1, 8'h05);
      u_ubs_link_peer.send(8'h5A);
      wait_irq;
      u_ubs_link_peer.send(8'hC3);
      cyc(20);
      rchk(4'h2, 8'h06);
      rd(4'h5, v);
      check("overrun", v[1], 1'b1);
      rchk(4'h0, 8'h5A);
      rchk(4'h9, 8'h00);
      cyc(3);
      check("irq_n", irq_n, 1'b1);
      wr(4'h1, 8'h00);
    end
  endtask
  task t_fifo;
    begin
      wr(4'h2, 8'h01);
      wr(4'h1, 8'h20);
      cyc(30);
      u_ubs_link_peer.send(8'h11);
      u_ubs_link_peer.send(8'h66);
      rchk(4'h2, 8'hD0);
      rchk(4'h9, 8'h02);
      rchk(4'h0, 8'h11);
      wr(4'h2, 8'h03);
      cyc(30);
      rchk(4'h9, 8'h00);
      wr(4'h4, 8'h04);
      wr(4'h6, 8'h5C);
      rchk(4'h6, 8'h5C);
      wr(4'h4, 8'h00);
      rchk(4'h6, 8'h00);
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #500000;
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    num_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    io_pin_in = 8'h3C;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    cyc(1);
    t_reset;
    t_banks;
    t_protect;
    t_thr;
    t_modem;
    t_rx;
    t_fifo;
    results;
  end
endmodule
